// *** src/cgf_pkg.sv ***
package cgf_pkg;
	// register byte offsets on the bus
	localparam logic [11:0] OFS_PTR  = 12'h000;
	localparam logic [11:0] OFS_BANK = 12'h004;
	localparam logic [11:0] OFS_PORT = 12'h008;
	localparam logic [11:0] OFS_TCTL = 12'h00c;
	localparam logic [11:0] OFS_STAT = 12'h010;
	// reset values
	localparam logic [7:0]  RST_PTR  = 8'h15;
	localparam logic [1:0]  RST_BANK = 2'h0;
	localparam logic [7:0]  RST_PORT = 8'h07;
	localparam logic [7:0]  RST_TCTL = 8'h01;
	// field positions
	localparam int PORT_IO_BIT  = 2;
	localparam int TCTL_KBD_BIT = 0;
	localparam int PTR_CS_LSB   = 1;
	localparam int PTR_CS_MSB   = 3;
	localparam int PTR_SCR_LSB  = 4;
	localparam int PTR_SCR_MSB  = 7;
	// rom image window inside a bank, in 4K units (offset 4096..8191)
	localparam logic [1:0]  ROM_IMAGE_4K = 2'h1;
	// top nibble of the processor window 53248..57343
	localparam logic [3:0]  CPU_WIN_HI = 4'hd;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CODE,
		ST_GLYPH
	} cgf_state_t;
endpackage

// *** src/cgf_top.sv ***
`timescale 1ns/1ps
module cgf_top (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        cell_req_in,
	input  wire logic [9:0]  cell_pos_in,
	input  wire logic [2:0]  cell_row_in,
	output logic             cell_busy_out,
	output logic             scr_rd_out,
	output logic      [15:0] scr_addr_out,
	output logic      [9:0]  col_addr_out,
	output logic             glyph_rd_out,
	output logic      [15:0] glyph_addr_out,
	output logic             glyph_rom_sel_out,
	input  wire logic        mem_ack_in,
	input  wire logic [7:0]  scr_data_in,
	input  wire logic [3:0]  col_data_in,
	input  wire logic [7:0]  glyph_data_in,
	output logic             pix_valid_out,
	output logic      [7:0]  pix_out,
	output logic      [3:0]  pix_col_out,
	input  wire logic        cpu_valid_in,
	input  wire logic [15:0] cpu_addr_in,
	output logic             cpu_rom_sel_out,
	output logic             cpu_io_sel_out,
	output logic      [11:0] cpu_rom_addr_out,
	input  wire logic        timer_irq_in,
	output logic             kbd_irq_out
);

	typedef struct packed {
		logic [7:0]          ptr;
		logic [1:0]          bank;
		logic [7:0]          port;
		logic [7:0]          tctl;
		logic                pready;
		logic [31:0]         prdata;
		logic                pslverr;
		cgf_pkg::cgf_state_t state;
		logic [2:0]          row;
		logic [7:0]          code;
		logic [3:0]          colour;
		logic                busy;
		logic                scr_rd;
		logic [15:0]         scr_addr;
		logic [9:0]          col_addr;
		logic                glyph_rd;
		logic [15:0]         glyph_addr;
		logic                glyph_rom;
		logic                pix_valid;
		logic [7:0]          pix;
		logic [3:0]          pix_col;
		logic                cpu_rom;
		logic                cpu_io;
		logic [11:0]         cpu_rom_addr;
		logic                kbd_irq;
	} cgf_regs_t;

	cgf_regs_t r;
	cgf_regs_t next_r;
	logic      setup_cyc;
	logic      access_done;
	logic      cpu_in_win;
	logic [13:0] glyph_ofs;

	// bus phase decode
	assign setup_cyc   = psel_in & ~penable_in;
	assign access_done = psel_in & penable_in & r.pready;
	// processor window 53248..57343
	assign cpu_in_win  = (cpu_addr_in[15:12] == cgf_pkg::CPU_WIN_HI);
	// glyph offset inside the bank, pointer bit 0 unused
	assign glyph_ofs = {r.ptr[cgf_pkg::PTR_CS_MSB:cgf_pkg::PTR_CS_LSB],
		scr_data_in, r.row};

	// next state of all registers
	always_comb
	begin
		next_r           = r;
		next_r.scr_rd    = 1'b0;
		next_r.glyph_rd  = 1'b0;
		next_r.pix_valid = 1'b0;
		// bus slave: answer prepared in setup, taken in access
		if (setup_cyc)
		begin
			next_r.pready  = 1'b1;
			next_r.pslverr = 1'b0;
			next_r.prdata  = 32'h0000_0000;
			case (paddr_in)
				cgf_pkg::OFS_PTR:
					next_r.prdata = {24'h00_0000, r.ptr};
				cgf_pkg::OFS_BANK:
					next_r.prdata = {30'h0000_0000, r.bank};
				cgf_pkg::OFS_PORT:
					next_r.prdata = {24'h00_0000, r.port};
				cgf_pkg::OFS_TCTL:
					next_r.prdata = {24'h00_0000, r.tctl};
				cgf_pkg::OFS_STAT:
					next_r.prdata = {28'h000_0000, r.cpu_rom,
						r.port[cgf_pkg::PORT_IO_BIT],
						r.tctl[cgf_pkg::TCTL_KBD_BIT], r.busy};
				default:
					next_r.pslverr = 1'b1;
			endcase
		end
		else if (access_done)
		begin
			next_r.pready  = 1'b0;
			next_r.pslverr = 1'b0;
			if (pwrite_in)
			begin
				case (paddr_in)
					cgf_pkg::OFS_PTR:
						next_r.ptr = pwdata_in[7:0];
					cgf_pkg::OFS_BANK:
						next_r.bank = pwdata_in[1:0];
					cgf_pkg::OFS_PORT:
						next_r.port = pwdata_in[7:0];
					cgf_pkg::OFS_TCTL:
						next_r.tctl = pwdata_in[7:0];
					default:
						next_r.ptr = r.ptr;
				endcase
			end
		end
		// video fetch sequence per screen position
		case (r.state)
			cgf_pkg::ST_IDLE:
			begin
				if (cell_req_in)
				begin
					next_r.row      = cell_row_in;
					// screen and colour read in the same slot
					next_r.scr_addr = {r.bank,
						r.ptr[cgf_pkg::PTR_SCR_MSB:cgf_pkg::PTR_SCR_LSB],
						cell_pos_in};
					next_r.col_addr = cell_pos_in;
					next_r.scr_rd   = 1'b1;
					next_r.busy     = 1'b1;
					next_r.state    = cgf_pkg::ST_CODE;
				end
			end
			cgf_pkg::ST_CODE:
			begin
				if (mem_ack_in)
				begin
					next_r.code       = scr_data_in;
					next_r.colour     = col_data_in;
					next_r.glyph_addr = {r.bank, glyph_ofs};
					// rom image only in even banks, ram elsewhere
					next_r.glyph_rom  = ~r.bank[0] &
						(glyph_ofs[13:12] == cgf_pkg::ROM_IMAGE_4K);
					next_r.glyph_rd   = 1'b1;
					next_r.state      = cgf_pkg::ST_GLYPH;
				end
			end
			cgf_pkg::ST_GLYPH:
			begin
				if (mem_ack_in)
				begin
					next_r.pix       = glyph_data_in;
					next_r.pix_col   = r.colour;
					next_r.pix_valid = 1'b1;
					next_r.busy      = 1'b0;
					next_r.state     = cgf_pkg::ST_IDLE;
				end
			end
			default:
			begin
				next_r.busy  = 1'b0;
				next_r.state = cgf_pkg::ST_IDLE;
			end
		endcase
		// processor window: rom or io by port bit 2
		next_r.cpu_rom = cpu_valid_in & cpu_in_win &
			~r.port[cgf_pkg::PORT_IO_BIT];
		next_r.cpu_io  = cpu_valid_in & cpu_in_win &
			r.port[cgf_pkg::PORT_IO_BIT];
		// rom byte index: low 12 bits of the processor address, one 4K window
		next_r.cpu_rom_addr = cpu_addr_in[11:0];
		// keyboard-scan interrupt gate
		next_r.kbd_irq = timer_irq_in &
			r.tctl[cgf_pkg::TCTL_KBD_BIT];
	end

	// single register stage, frozen while ce is low
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			r       <= '0;
			r.ptr   <= cgf_pkg::RST_PTR;
			r.bank  <= cgf_pkg::RST_BANK;
			r.port  <= cgf_pkg::RST_PORT;
			r.tctl  <= cgf_pkg::RST_TCTL;
			r.state <= cgf_pkg::ST_IDLE;
		end
		else if (ce_in)
		begin
			r <= next_r;
		end
	end

	// outputs straight from the register stage
	assign prdata_out        = r.prdata;
	assign pready_out        = r.pready;
	assign pslverr_out       = r.pslverr;
	assign cell_busy_out     = r.busy;
	assign scr_rd_out        = r.scr_rd;
	assign scr_addr_out      = r.scr_addr;
	assign col_addr_out      = r.col_addr;
	assign glyph_rd_out      = r.glyph_rd;
	assign glyph_addr_out    = r.glyph_addr;
	assign glyph_rom_sel_out = r.glyph_rom;
	assign pix_valid_out     = r.pix_valid;
	assign pix_out           = r.pix;
	assign pix_col_out       = r.pix_col;
	assign cpu_rom_sel_out   = r.cpu_rom;
	assign cpu_io_sel_out    = r.cpu_io;
	assign cpu_rom_addr_out  = r.cpu_rom_addr;
	assign kbd_irq_out       = r.kbd_irq;

	// glyph address carries code and row
	glyph_addr_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		glyph_rd_out |-> (glyph_addr_out[10:3] == r.code) &&
			(glyph_addr_out[2:0] == r.row))
		else $error("glyph address not code*8+row");

	// set and bank fields of glyph address
	glyph_base_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && r.state == cgf_pkg::ST_CODE && mem_ack_in &&
			!access_done) |=> glyph_rd_out &&
			(glyph_addr_out[13:11] == $past(r.ptr[3:1])) &&
			(glyph_addr_out[15:14] == $past(r.bank)))
		else $error("glyph base not from pointer and bank");

	// colour taken in same slot as code
	code_colour_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		scr_rd_out |-> col_addr_out == scr_addr_out[9:0])
		else $error("colour address differs from screen position");

	// rom image only in even banks at 4K..8K
	rom_image_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		glyph_rd_out |-> glyph_rom_sel_out ==
			(!glyph_addr_out[14] &&
			glyph_addr_out[13:12] == cgf_pkg::ROM_IMAGE_4K))
		else $error("rom image select wrong");

	// pixel byte follows glyph acknowledge
	pix_out_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && r.state == cgf_pkg::ST_GLYPH && mem_ack_in) |=>
			pix_valid_out && pix_out == $past(glyph_data_in))
		else $error("pixel byte not delivered");

	// processor window follows port bit 2
	cpu_rom_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && cpu_valid_in &&
			cpu_addr_in[15:12] == cgf_pkg::CPU_WIN_HI &&
			!r.port[cgf_pkg::PORT_IO_BIT]) |=>
			cpu_rom_sel_out && !cpu_io_sel_out)
		else $error("rom not mapped with port bit clear");

	cpu_io_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && cpu_valid_in &&
			cpu_addr_in[15:12] == cgf_pkg::CPU_WIN_HI &&
			r.port[cgf_pkg::PORT_IO_BIT]) |=>
			cpu_io_sel_out && !cpu_rom_sel_out)
		else $error("io not mapped with port bit set");

	// keyboard interrupt gated by timer control bit
	kbd_gate_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		ce_in |=> kbd_irq_out ==
			($past(timer_irq_in) &&
			$past(r.tctl[cgf_pkg::TCTL_KBD_BIT])))
		else $error("keyboard interrupt gate wrong");

	// every bus setup answered in the next cycle
	bus_ready_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && setup_cyc) |=> pready_out)
		else $error("no ready after setup");

	// pointer write lands at the completing edge
	ptr_write_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && access_done && pwrite_in &&
			paddr_in == cgf_pkg::OFS_PTR) |=>
			r.ptr == $past(pwdata_in[7:0]))
		else $error("pointer write lost");

	// port write moves the window switch bit
	port_write_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && access_done && pwrite_in &&
			paddr_in == cgf_pkg::OFS_PORT) |=>
			r.port[cgf_pkg::PORT_IO_BIT] ==
			$past(pwdata_in[cgf_pkg::PORT_IO_BIT]))
		else $error("port switch bit not written");

	// a fetch request starts the paired screen and colour read
	fetch_start_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && r.state == cgf_pkg::ST_IDLE && cell_req_in) |=>
			scr_rd_out && cell_busy_out &&
			(col_addr_out == $past(cell_pos_in)) &&
			(scr_addr_out[9:0] == $past(cell_pos_in)))
		else $error("screen and colour read not paired");

	// cell row latched for the low glyph address bits
	row_latch_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		(ce_in && r.state == cgf_pkg::ST_IDLE && cell_req_in) |=>
			r.row == $past(cell_row_in))
		else $error("cell row not latched");

	// rom byte index follows processor address
	rom_index_a: assert property (@(posedge sys_clk_in)
		disable iff (!rst_n_in)
		ce_in |=> cpu_rom_addr_out == $past(cpu_addr_in[11:0]))
		else $error("rom byte index wrong");

endmodule

// *** tb/cgf_mem_model.sv ***
`timescale 1ns/1ps
module cgf_mem_model (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [3:0]  dly_in,
	input  wire logic        scr_rd_in,
	input  wire logic [15:0] scr_addr_in,
	input  wire logic [9:0]  col_addr_in,
	input  wire logic        glyph_rd_in,
	input  wire logic [15:0] glyph_addr_in,
	input  wire logic        glyph_rom_sel_in,
	output logic             mem_ack_out,
	output logic      [7:0]  scr_data_out,
	output logic      [3:0]  col_data_out,
	output logic      [7:0]  glyph_data_out
);
	logic is_g;
	initial
	begin
		mem_ack_out = 1'b0;
		scr_data_out = 8'h00;
		col_data_out = 4'h0;
		glyph_data_out = 8'h00;
	end
	// answer each strobe after dly_in cycles, then scramble idle data
	always
	begin
		@(posedge clk_in);
		if (rst_n_in && (scr_rd_in || glyph_rd_in))
		begin
			is_g = glyph_rd_in;
			repeat (dly_in) @(posedge clk_in);
			mem_ack_out <= 1'b1;
			if (is_g)
				glyph_data_out <= glyph_rom_sel_in ? ~glyph_addr_in[7:0]
					: glyph_addr_in[7:0];
			else
			begin
				scr_data_out <= scr_addr_in[7:0] ^ 8'h5a;
				col_data_out <= col_addr_in[3:0];
			end
			@(posedge clk_in);
			mem_ack_out <= 1'b0;
			scr_data_out <= ~scr_data_out;
			col_data_out <= ~col_data_out;
			glyph_data_out <= ~glyph_data_out;
		end
	end
endmodule

// *** tb/tb_char_generator_fetch_map.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) \
	begin \
		comparisons++; \
		if ((s) !== (e)) \
		begin \
			err_total++; \
			$display("[ERR] %s exp %h got %h", n, e, s); \
		end \
	end
module tb_char_generator_fetch_map;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, req = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwd = 0, rd;
	logic [9:0] pos = 0;
	logic [2:0] row = 0;
	logic [3:0] dly = 0, cold;
	logic cv = 0, tirq = 0, ack, err, busy, srd, grd, gsel, pv;
	logic crs, cio, kirq, rdy, ce = 1;
	logic [15:0] ca = 0, sa, ga;
	logic [9:0] cla;
	logic [7:0] sd, gd, pix;
	logic [3:0] pc;
	logic [11:0] cra;
	int err_total = 0, comparisons = 0;
	always #25 clk = ~clk;
	cgf_top DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
		.pwdata_in(pwd), .prdata_out(rd), .pready_out(rdy),
		.pslverr_out(err), .cell_req_in(req), .cell_pos_in(pos),
		.cell_row_in(row), .cell_busy_out(busy), .scr_rd_out(srd),
		.scr_addr_out(sa), .col_addr_out(cla), .glyph_rd_out(grd),
		.glyph_addr_out(ga), .glyph_rom_sel_out(gsel), .mem_ack_in(ack),
		.scr_data_in(sd), .col_data_in(cold), .glyph_data_in(gd),
		.pix_valid_out(pv), .pix_out(pix), .pix_col_out(pc),
		.cpu_valid_in(cv), .cpu_addr_in(ca), .cpu_rom_sel_out(crs),
		.cpu_io_sel_out(cio), .cpu_rom_addr_out(cra),
		.timer_irq_in(tirq), .kbd_irq_out(kirq));
	cgf_mem_model MEM (.clk_in(clk), .rst_n_in(rst_n), .dly_in(dly),
		.scr_rd_in(srd), .scr_addr_in(sa), .col_addr_in(cla),
		.glyph_rd_in(grd), .glyph_addr_in(ga), .glyph_rom_sel_in(gsel),
		.mem_ack_out(ack), .scr_data_out(sd), .col_data_out(cold),
		.glyph_data_out(gd));
	task end_sim;
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// this wait ends when rdy is sampled high, else the watchdog ends it
		do
			@(posedge clk);
		while (rdy !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// register values after reset and an unmapped access
	task t_reset;
		apb(0, cgf_pkg::OFS_PTR, 0);
		`CHK("ptr", 32'h0000_0015, rd)
		apb(0, cgf_pkg::OFS_BANK, 0);
		`CHK("bank", 32'h0000_0000, rd)
		apb(0, cgf_pkg::OFS_PORT, 0);
		`CHK("port", 32'h0000_0007, rd)
		apb(0, cgf_pkg::OFS_TCTL, 0);
		`CHK("tctl", 32'h0000_0001, rd)
		apb(0, 12'h020, 0);
		`CHK("unmapped", 1'b1, err)
		`CHK("unmapped data", 32'h0000_0000, rd)
	endtask
	// glyph fetch over a table of bank, pointer and position, row from the loop index
	task t_fetch;
		logic [1:0] bk [5];
		logic [7:0] pt [5];
		logic [9:0] ps [5];
		logic [7:0] code;
		logic [15:0] eg;
		logic er;
		int n;
		bk = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
		pt = '{8'h15, 8'h15, 8'h17, 8'h1c, 8'h1d};
		ps = '{10'h003, 10'h044, 10'h3ff, 10'h100, 10'h0ff};
		for (int i = 0; i < 5; i++)
		begin
			apb(1, cgf_pkg::OFS_PTR, {24'h00_0000, pt[i]});
			apb(1, cgf_pkg::OFS_BANK, {30'h0000_0000, bk[i]});
			code = ps[i][7:0] ^ 8'h5a;
			eg = 16'(bk[i] * 16384 + pt[i][3:1] * 2048 + code * 8 + i[2:0]);
			er = !bk[i][0] && eg[13:12] == 2'h1;
			n = 0;
			@(posedge clk);
			dly <= i[3:0];
			pos <= ps[i];
			row <= i[2:0];
			req <= 1'b1;
			@(posedge clk);
			req <= 1'b0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (pv !== 1'b1 && n < 40);
			`CHK("scr_addr", {bk[i], pt[i][7:4], ps[i]}, sa)
			`CHK("col_addr", ps[i], cla)
			`CHK("glyph_addr", eg, ga)
			`CHK("row bits", i[2:0], ga[2:0])
			`CHK("rom_sel", er, gsel)
			`CHK("pix", er ? ~eg[7:0] : eg[7:0], pix)
			`CHK("pix_col", ps[i][3:0], pc)
			`CHK("busy", 1'b0, busy)
		end
	endtask
	// processor window switching and keyboard interrupt gating
	task t_cpu;
		apb(1, cgf_pkg::OFS_TCTL, 0);
		tirq <= 1;
		repeat (2) @(posedge clk);
		`CHK("kbd_irq off", 1'b0, kirq)
		apb(1, cgf_pkg::OFS_PORT, 32'h0000_0003);
		cv <= 1;
		ca <= 16'hd008;
		repeat (2) @(posedge clk);
		`CHK("rom sel", 1'b1, crs)
		`CHK("io sel", 1'b0, cio)
		`CHK("rom addr", 12'h008, cra)
		ca <= 16'hdfff;
		repeat (2) @(posedge clk);
		`CHK("rom top", 12'hfff, cra)
		// status: rom hit, io out, keyboard off, idle
		apb(0, cgf_pkg::OFS_STAT, 0);
		`CHK("stat", 32'h0000_0008, rd)
		apb(1, cgf_pkg::OFS_PORT, 32'h0000_0007);
		repeat (2) @(posedge clk);
		`CHK("io back", 1'b1, cio)
		`CHK("rom off", 1'b0, crs)
		apb(1, cgf_pkg::OFS_TCTL, 1);
		repeat (2) @(posedge clk);
		`CHK("kbd_irq on", 1'b1, kirq)
		// clock enable low freezes the gated interrupt
		ce <= 1'b0;
		tirq <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("kbd_irq frozen", 1'b1, kirq)
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("kbd_irq idle", 1'b0, kirq)
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_fetch();
		t_cpu();
		end_sim();
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		end_sim();
	end
endmodule
